// ### common/ucpwm_pkg.sv
// package: register map, field layout, mode codes and helpers of the pwm unified channel
package ucpwm_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] UCPWM_OFS_CTRL   = 8'h00;
    localparam logic [7:0] UCPWM_OFS_DATA_A = 8'h04;
    localparam logic [7:0] UCPWM_OFS_DATA_B = 8'h08;
    localparam logic [7:0] UCPWM_OFS_COUNT  = 8'h0C;
    localparam logic [7:0] UCPWM_OFS_STATUS = 8'h10;
    localparam logic [7:0] UCPWM_OFS_DEAD   = 8'h14;

    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int UCPWM_CTRL_MODE_LSB = 0;
    localparam int UCPWM_CTRL_PRE_LSB  = 8;
    localparam int UCPWM_CTRL_FREEZE   = 12;
    localparam int UCPWM_CTRL_DEAD_EN  = 13;
    localparam int UCPWM_CTRL_INVERT   = 14;
    localparam int UCPWM_CTRL_W        = 15;

    // status bit positions
    localparam int UCPWM_ST_WRAP       = 0;
    localparam int UCPWM_ST_BUS_FAULT  = 1;
    localparam int UCPWM_ST_DEAD_FAULT = 2;
    localparam int UCPWM_ST_RELOAD     = 3;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [14:0] UCPWM_RST_CTRL  = 15'h0000;
    localparam logic [15:0] UCPWM_RST_DATA  = 16'h0000;
    localparam logic [15:0] UCPWM_RST_COUNT = 16'h0001;
    localparam logic [7:0]  UCPWM_RST_DEAD  = 8'h00;

    // ------------------------------------------------------------
    // mode codes
    // ------------------------------------------------------------
    localparam logic [6:0] UCPWM_MODE_FREQ_PWM_0 = 7'h58;
    localparam logic [6:0] UCPWM_MODE_FREQ_PWM_1 = 7'h5A;
    localparam logic [6:0] UCPWM_MODE_MODCNT_0   = 7'h10;
    localparam logic [6:0] UCPWM_MODE_MODCNT_1   = 7'h11;
    localparam logic [6:0] UCPWM_MODE_BMODCNT_0  = 7'h50;
    localparam logic [6:0] UCPWM_MODE_BMODCNT_1  = 7'h51;
    localparam logic [6:0] UCPWM_MODE_EDGE_PWM   = 7'h60;
    localparam logic [6:0] UCPWM_MODE_CENTER_PWM = 7'h5C;

    // wrap tracking state
    typedef enum logic [0:0] {
        UCPWM_WRAP_NONE   = 1'b0,
        UCPWM_WRAP_ACTIVE = 1'b1
    } ucpwm_wrap_t;

    // ------------------------------------------------------------
    // mode decoders
    // ------------------------------------------------------------
    function automatic logic ucpwm_is_freq(input logic [6:0] m);
        return (m == UCPWM_MODE_FREQ_PWM_0) || (m == UCPWM_MODE_FREQ_PWM_1);
    endfunction : ucpwm_is_freq

    function automatic logic ucpwm_is_modcnt(input logic [6:0] m);
        return (m == UCPWM_MODE_MODCNT_0) || (m == UCPWM_MODE_MODCNT_1);
    endfunction : ucpwm_is_modcnt

    function automatic logic ucpwm_is_bmodcnt(input logic [6:0] m);
        return (m == UCPWM_MODE_BMODCNT_0) || (m == UCPWM_MODE_BMODCNT_1);
    endfunction : ucpwm_is_bmodcnt

endpackage : ucpwm_pkg

// ### hdl/ucpwm_prescaler.sv
// module: internal prescaler that divides the global tick by ratio plus one
`timescale 1ns/1ps
`default_nettype none

module ucpwm_prescaler
    import ucpwm_pkg::*;
#(
    parameter int PRE_W = 2
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clkEn,
    // tick in, ratio, tick out
    input  wire logic             tickIn,
    input  wire logic [PRE_W-1:0] ratio,
    output logic                  tickOut
);

    logic [PRE_W-1:0] divCnt_q;
    logic [PRE_W-1:0] divCnt_d;
    logic             atEnd;

    assign atEnd    = (divCnt_q >= ratio);
    assign tickOut  = tickIn && atEnd;
    assign divCnt_d = atEnd ? '0 : divCnt_q + 1'b1;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            divCnt_q <= '0;
        end else if (clkEn && tickIn) begin
            divCnt_q <= divCnt_d;
        end
    end

endmodule : ucpwm_prescaler

`default_nettype wire

// ### hdl/ucpwm_channel.sv
// module: pwm unified channel with buffered counter modes, register port and counter bus
`timescale 1ns/1ps
`default_nettype none

// Function
// - In buffered frequency pwm mode the counter counts up from one to the active b value.
// - While frozen, a write to the count register overwrites the internal counter.
// - A count placed above the active b value wraps through the full range and the output is then not guaranteed.
// - In buffered frequency pwm and buffered modulus count modes rollover returns the counter to zero, not one.
// - When the counter comes back to one after a wrap, the shadow a and b values are not moved to the active ones.
// - Buffered edge or center pwm fed by a modulus count channel whose prescaler divides by more than one malfunctions.
// - Center pwm with dead time on a buffered modulus count timebase of different prescaler malfunctions.
module ucpwm_channel
    import ucpwm_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int PRE_W = 2,
    parameter int DT_W  = 8
) (
    // clock, reset, enable
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clkEn,
    // register port
    input  wire logic [7:0]       regAddr,
    input  wire logic [31:0]      regWdata,
    input  wire logic             regWr,
    input  wire logic             regRd,
    output logic [31:0]           regRdata,
    // global prescaler tick
    input  wire logic             globalTick,
    // counter bus from the source channel
    input  wire logic [CNT_W-1:0] busCount,
    input  wire logic [6:0]       busSrcMode,
    input  wire logic [PRE_W-1:0] busSrcPrescale,
    input  wire logic             busSrcGlobalDiv,
    // outputs
    output logic                  pwmOut,
    output logic [CNT_W-1:0]      countOut,
    output logic                  modeFault
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [UCPWM_CTRL_W-1:0] ctrl_q;
    logic [CNT_W-1:0]        count_q, count_d;
    logic [CNT_W-1:0]        activeA_q, activeB_q;
    logic [CNT_W-1:0]        shadowA_q, shadowB_q;
    logic [DT_W-1:0]         deadTime_q;
    logic [DT_W-1:0]         deadCnt_q, deadCnt_d;
    ucpwm_wrap_t             wrap_q, wrap_d;
    logic                    reloadSeen_q;
    logic                    rawOut_q;
    logic                    pwmOut_q, pwmOut_d;
    logic                    busFault_q, deadFault_q;
    logic [31:0]             regRdata_q, regRdata_d;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic [6:0]       mode     = ctrl_q[UCPWM_CTRL_MODE_LSB +: 7];
    wire logic [PRE_W-1:0] prescale = ctrl_q[UCPWM_CTRL_PRE_LSB +: PRE_W];
    wire logic             freeze   = ctrl_q[UCPWM_CTRL_FREEZE];
    wire logic             deadEn   = ctrl_q[UCPWM_CTRL_DEAD_EN];
    wire logic             invert   = ctrl_q[UCPWM_CTRL_INVERT];

    wire logic freqMode   = ucpwm_is_freq(mode);
    wire logic bModMode   = ucpwm_is_bmodcnt(mode);
    wire logic countMode  = freqMode || bModMode || ucpwm_is_modcnt(mode);
    wire logic edgeMode   = (mode == UCPWM_MODE_EDGE_PWM);
    wire logic centerMode = (mode == UCPWM_MODE_CENTER_PWM);
    wire logic busMode    = edgeMode || centerMode;

    wire logic wrCtrl   = regWr && (regAddr == UCPWM_OFS_CTRL);
    wire logic wrA      = regWr && (regAddr == UCPWM_OFS_DATA_A);
    wire logic wrB      = regWr && (regAddr == UCPWM_OFS_DATA_B);
    wire logic wrCount  = regWr && (regAddr == UCPWM_OFS_COUNT) && freeze;
    wire logic wrStatus = regWr && (regAddr == UCPWM_OFS_STATUS);
    wire logic wrDead   = regWr && (regAddr == UCPWM_OFS_DEAD);

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic ownTick;

    ucpwm_prescaler #(
        .PRE_W   (PRE_W)
    ) u_prescaler (
        .sys_clk (sys_clk),
        .rst     (rst),
        .clkEn   (clkEn),
        .tickIn  (globalTick),
        .ratio   (prescale),
        .tickOut (ownTick)
    );

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    wire logic step      = ownTick && !freeze && countMode && !wrCount;
    wire logic atTop     = (count_q == activeB_q);
    wire logic atZero    = (count_q == '0);
    wire logic aboveTop  = countMode && (count_q > activeB_q);
    wire logic restart   = step && atZero;
    wire logic busRestart = busMode && ownTick && (busCount == CNT_W'(1));
    wire logic reloadEn  = ((restart && (wrap_q == UCPWM_WRAP_NONE)) || busRestart) && !bModMode
                           || (restart && bModMode && (wrap_q == UCPWM_WRAP_NONE));

    always_comb begin
        count_d = count_q;
        if (wrCount) begin
            count_d = regWdata[CNT_W-1:0];
        end else if (step) begin
            if (atTop) begin
                count_d = '0;
            end else if (atZero) begin
                count_d = CNT_W'(1);
            // above top runs on to the natural wrap
            end else begin
                count_d = count_q + 1'b1;
            end
        end
    end

    // wrap tracking blocks the next reload
    assign wrap_d = aboveTop ? UCPWM_WRAP_ACTIVE
                  : (restart ? UCPWM_WRAP_NONE : wrap_q);

    // ------------------------------------------------------------
    // output waveform
    // ------------------------------------------------------------
    wire logic rawOut = freqMode   ? (count_q < activeA_q)
                      : edgeMode   ? (busCount < activeA_q)
                      : centerMode ? ((busCount >= activeA_q) && (busCount < activeB_q))
                      : 1'b0;
    wire logic rawRise = rawOut && !rawOut_q;
    wire logic deadOn  = centerMode && deadEn;

    // lead dead time holds the output off after each rising edge
    assign deadCnt_d = (deadOn && rawRise) ? deadTime_q
                     : ((ownTick && (deadCnt_q != '0)) ? deadCnt_q - 1'b1 : deadCnt_q);
    assign pwmOut_d  = (rawOut && !(deadOn && (rawRise || (deadCnt_q != '0))) ) ^ invert;

    // ------------------------------------------------------------
    // counter-bus hazards
    // ------------------------------------------------------------
    // prescaled modulus count bus
    wire logic busHazard  = busMode && ucpwm_is_modcnt(busSrcMode)
                            && ((busSrcPrescale != '0) || busSrcGlobalDiv);
    wire logic deadHazard = deadOn && ucpwm_is_bmodcnt(busSrcMode) && (busSrcPrescale != prescale);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire logic [31:0] statusWord = {28'h000_0000, reloadSeen_q, deadFault_q, busFault_q, wrap_q == UCPWM_WRAP_ACTIVE};
    wire logic [31:0] rdMux = (regAddr == UCPWM_OFS_CTRL)   ? 32'(ctrl_q)
                            : (regAddr == UCPWM_OFS_DATA_A) ? 32'(activeA_q)
                            : (regAddr == UCPWM_OFS_DATA_B) ? 32'(activeB_q)
                            : (regAddr == UCPWM_OFS_COUNT)  ? 32'(count_q)
                            : (regAddr == UCPWM_OFS_STATUS) ? statusWord
                            : (regAddr == UCPWM_OFS_DEAD)   ? 32'(deadTime_q)
                            : 32'h0000_0000;
    assign regRdata_d = regRd ? rdMux : 32'h0000_0000;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_q     <= UCPWM_RST_CTRL;
            deadTime_q <= UCPWM_RST_DEAD;
            shadowA_q  <= CNT_W'(UCPWM_RST_DATA);
            shadowB_q  <= CNT_W'(UCPWM_RST_DATA);
            regRdata_q <= 32'h0000_0000;
        end else if (clkEn) begin
            if (wrCtrl) ctrl_q <= regWdata[UCPWM_CTRL_W-1:0];
            if (wrDead) deadTime_q <= regWdata[DT_W-1:0];
            if (wrA) shadowA_q <= regWdata[CNT_W-1:0];
            if (wrB) shadowB_q <= regWdata[CNT_W-1:0];
            regRdata_q <= regRdata_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_q   <= CNT_W'(UCPWM_RST_COUNT);
            wrap_q    <= UCPWM_WRAP_NONE;
            activeA_q <= CNT_W'(UCPWM_RST_DATA);
            activeB_q <= CNT_W'(UCPWM_RST_DATA);
        end else if (clkEn) begin
            count_q <= count_d;
            wrap_q  <= wrap_d;
            if (reloadEn) begin
                activeA_q <= shadowA_q;
                activeB_q <= shadowB_q;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            deadCnt_q    <= '0;
            rawOut_q     <= 1'b0;
            pwmOut_q     <= 1'b0;
            busFault_q   <= 1'b0;
            deadFault_q  <= 1'b0;
            reloadSeen_q <= 1'b0;
        end else if (clkEn) begin
            deadCnt_q   <= deadCnt_d;
            rawOut_q    <= rawOut;
            pwmOut_q    <= pwmOut_d;
            busFault_q  <= busHazard;
            deadFault_q <= deadHazard;
            // sticky, write one to clear, a new reload wins
            reloadSeen_q <= reloadEn || (reloadSeen_q && !(wrStatus && regWdata[UCPWM_ST_RELOAD]));
        end
    end

    assign regRdata  = regRdata_q;
    assign pwmOut    = pwmOut_q;
    assign countOut  = count_q;
    assign modeFault = busFault_q || deadFault_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence seqAtTop;
        clkEn && step && atTop;
    endsequence

    sequence seqAtZero;
        clkEn && step && atZero;
    endsequence

    chk_rollover_zero: assert property (seqAtTop |=> (count_q == '0))
        else $error("rollover did not return the counter to zero");
    chk_restart_one: assert property (seqAtZero |=> (count_q == CNT_W'(1)))
        else $error("counter did not restart at one");
    chk_freeze_write: assert property (clkEn && wrCount |=> (count_q == $past(regWdata[CNT_W-1:0])))
        else $error("frozen count write was not taken");
    chk_wrap_mark: assert property (clkEn && aboveTop |=> (wrap_q == UCPWM_WRAP_ACTIVE))
        else $error("count above top did not mark a wrap");
    chk_no_reload_wrap: assert property (seqAtZero and (wrap_q == UCPWM_WRAP_ACTIVE) && !busRestart
                                         |=> $stable(activeB_q) && $stable(activeA_q))
        else $error("active values reloaded after a wrap");
    chk_reload_restart: assert property (seqAtZero and (wrap_q == UCPWM_WRAP_NONE)
                                         |=> (activeB_q == $past(shadowB_q)) && (activeA_q == $past(shadowA_q)))
        else $error("shadow values not moved at period start");
    chk_bus_hazard: assert property (clkEn && busHazard |=> modeFault ##1 1'b1)
        else $error("prescaled modulus bus not flagged");
    chk_dead_hazard: assert property (clkEn && deadHazard |=> deadFault_q && modeFault)
        else $error("dead time prescaler mismatch not flagged");

endmodule : ucpwm_channel

`default_nettype wire

// ### verification/test_pwm_channel_counter_modes.sv
// testbench: register-port and pin checks of the pwm unified channel counter modes
`timescale 1ns/1ps
`default_nettype none

module test_pwm_channel_counter_modes;
    import ucpwm_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        sys_clk;
    logic        rst;
    logic        clkEn;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    logic        globalTick;
    logic [15:0] busCount;
    logic [6:0]  busSrcMode;
    logic [1:0]  busSrcPrescale;
    logic        busSrcGlobalDiv;
    logic        pwmOut;
    logic [15:0] countOut;
    logic        modeFault;
    logic [31:0] rdVal;
    logic [6:0]  modeList [4];
    int          nMismatch;
    int          checkCount;

    ucpwm_channel #(.CNT_W(16), .PRE_W(2), .DT_W(8)) DUT (
        .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .globalTick(globalTick), .busCount(busCount), .busSrcMode(busSrcMode),
        .busSrcPrescale(busSrcPrescale), .busSrcGlobalDiv(busSrcGlobalDiv),
        .pwmOut(pwmOut), .countOut(countOut), .modeFault(modeFault)
    );

    always #50 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic endSim();
        if (nMismatch == 0 && checkCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : endSim

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp32

    task automatic regWrite(input logic [7:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        regWr    <= 1'b1;
        regAddr  <= addr;
        regWdata <= data;
        @(posedge sys_clk);
        regWr    <= 1'b0;
    endtask : regWrite

    // read data stand only in the cycle after the strobe
    task automatic regCheck(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
        @(posedge sys_clk);
        regRd   <= 1'b1;
        regAddr <= addr;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        #1;
        rdVal = regRdata;
        cmp32(rdVal & mask, exp, "register read");
    endtask : regCheck

    // follow the counter for ten ticks; pwm level lags the count by one cycle
    task automatic walkCount(input logic [15:0] bVal, input logic [15:0] aVal, input logic inv, input logic pwmChk);
        logic [15:0] prev;
        logic [15:0] expCnt;
        repeat (3) @(posedge sys_clk);
        #1;
        prev = countOut;
        for (int k = 0; k < 10; k++) begin
            expCnt = (prev == bVal) ? 16'h0000 : (prev == 16'h0000) ? 16'h0001 : prev + 16'h0001;
            @(posedge sys_clk);
            #1;
            cmp32({16'h0000, countOut}, {16'h0000, expCnt}, "count step");
            if (pwmChk) begin
                cmp32({31'h0000_0000, pwmOut}, {31'h0000_0000, (prev < aVal) ^ inv}, "pwm level");
            end
            prev = countOut;
        end
    endtask : walkCount

    task automatic waitCount(input logic [15:0] v);
        int k;
        k = 0;
        @(posedge sys_clk);
        #1;
        while (countOut !== v && k < 100) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        if (k >= 100) begin
            nMismatch++;
            $display("unexpected at %0t: counter wait ran out", $time);
            endSim();
        end
    endtask : waitCount

    task automatic faultCheck(input logic [6:0] src, input logic [1:0] pre, input logic glb, input logic exp);
        @(posedge sys_clk);
        busSrcMode      <= src;
        busSrcPrescale  <= pre;
        busSrcGlobalDiv <= glb;
        repeat (3) @(posedge sys_clk);
        #1;
        cmp32({31'h0000_0000, modeFault}, {31'h0000_0000, exp}, "fault flag");
    endtask : faultCheck

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        clkEn = 1'b1;
        regAddr = 8'h00;
        regWdata = 32'h0000_0000;
        regWr = 1'b0;
        regRd = 1'b0;
        globalTick = 1'b1;
        busCount = 16'h0005;
        busSrcMode = 7'h00;
        busSrcPrescale = 2'h0;
        busSrcGlobalDiv = 1'b0;
        nMismatch = 0;
        checkCount = 0;
        modeList = '{UCPWM_MODE_FREQ_PWM_0, UCPWM_MODE_FREQ_PWM_1, UCPWM_MODE_BMODCNT_0, UCPWM_MODE_BMODCNT_1};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        cmp32({16'h0000, countOut}, 32'h0000_0001, "count after reset");
        regCheck(UCPWM_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
        regCheck(UCPWM_OFS_DATA_B, 32'hFFFF_FFFF, 32'h0000_0000);
        regCheck(UCPWM_OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_0001);
        regCheck(UCPWM_OFS_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        regCheck(8'h18, 32'hFFFF_FFFF, 32'h0000_0000);
        regWrite(UCPWM_OFS_DEAD, 32'h0000_01FF);
        regCheck(UCPWM_OFS_DEAD, 32'hFFFF_FFFF, 32'h0000_00FF);
        // shadow values move to active on a bus restart at one
        regWrite(UCPWM_OFS_DATA_A, 32'h0000_0002);
        regWrite(UCPWM_OFS_DATA_B, 32'h0000_0003);
        regWrite(UCPWM_OFS_CTRL, 32'(UCPWM_MODE_EDGE_PWM));
        @(posedge sys_clk);
        busCount <= 16'h0001;
        repeat (4) @(posedge sys_clk);
        busCount <= 16'h0005;
        regCheck(UCPWM_OFS_DATA_A, 32'hFFFF_FFFF, 32'h0000_0002);       // active a loaded
        regCheck(UCPWM_OFS_DATA_B, 32'hFFFF_FFFF, 32'h0000_0003);       // active b loaded
        regCheck(UCPWM_OFS_STATUS, 32'h0000_0008, 32'h0000_0008);
        // count overwrite while frozen
        regWrite(UCPWM_OFS_CTRL, 32'(UCPWM_MODE_FREQ_PWM_0) | 32'h0000_1000);
        regWrite(UCPWM_OFS_COUNT, 32'h0000_0002);                           // overwrite within 1..b
        regCheck(UCPWM_OFS_COUNT, 32'hFFFF_FFFF, 32'h0000_0002);        // frozen overwrite
        // buffered frequency pwm and buffered modulus count modes: 1 up to b, then rollover to zero
        for (int i = 0; i < 4; i++) begin
            regWrite(UCPWM_OFS_CTRL, 32'(modeList[i]) | 32'h0000_1000 | (i == 1 ? 32'h0000_4000 : 32'h0000_0000));
            regWrite(UCPWM_OFS_COUNT, 32'h0000_0001);                       // enter mode inside 1..b
            regWrite(UCPWM_OFS_CTRL, 32'(modeList[i]) | (i == 1 ? 32'h0000_4000 : 32'h0000_0000));
            walkCount(16'h0003, 16'h0002, i == 1, i < 2);                   // count range and rollover
        end
        // new period and duty take effect at restart
        regWrite(UCPWM_OFS_CTRL, 32'(UCPWM_MODE_FREQ_PWM_0));
        regWrite(UCPWM_OFS_DATA_B, 32'h0000_0004);
        regWrite(UCPWM_OFS_DATA_A, 32'h0000_0001);
        repeat (8) @(posedge sys_clk);
        regCheck(UCPWM_OFS_DATA_B, 32'hFFFF_FFFF, 32'h0000_0004);       // reload at restart
        walkCount(16'h0004, 16'h0001, 1'b0, 1'b1);                          // longer period
        // overwrite above b: wrap through all-ones, first restart skips the reload
        regWrite(UCPWM_OFS_CTRL, 32'(UCPWM_MODE_FREQ_PWM_0) | 32'h0000_1000);
        regWrite(UCPWM_OFS_COUNT, 32'h0000_FFF0);
        regWrite(UCPWM_OFS_DATA_B, 32'h0000_0002);
        regWrite(UCPWM_OFS_CTRL, 32'(UCPWM_MODE_FREQ_PWM_0));
        regCheck(UCPWM_OFS_STATUS, 32'h0000_0001, 32'h0000_0001);       // wrap flagged
        waitCount(16'h0000);                                                // wrap passes zero
        waitCount(16'h0001);
        regCheck(UCPWM_OFS_DATA_B, 32'hFFFF_FFFF, 32'h0000_0004);       // no reload after wrap
        waitCount(16'h0000);
        waitCount(16'h0001);
        repeat (2) @(posedge sys_clk);
        regCheck(UCPWM_OFS_DATA_B, 32'hFFFF_FFFF, 32'h0000_0002);       // next restart reloads
        // prescaled modulus source feeding edge and center pwm
        for (int i = 0; i < 4; i++) begin
            regWrite(UCPWM_OFS_CTRL, 32'(i < 2 ? UCPWM_MODE_EDGE_PWM : UCPWM_MODE_CENTER_PWM));
            faultCheck(i[0] ? UCPWM_MODE_MODCNT_1 : UCPWM_MODE_MODCNT_0, 2'h1, 1'b0, 1'b1);   // internal divide
            faultCheck(i[0] ? UCPWM_MODE_MODCNT_1 : UCPWM_MODE_MODCNT_0, 2'h0, 1'b1, 1'b1);   // global divide
            faultCheck(i[0] ? UCPWM_MODE_MODCNT_1 : UCPWM_MODE_MODCNT_0, 2'h0, 1'b0, 1'b0);   // undivided safe
        end
        faultCheck(UCPWM_MODE_BMODCNT_0, 2'h1, 1'b1, 1'b0);                 // buffered source safe
        // dead-time center pwm on a buffered modulus timebase
        regWrite(UCPWM_OFS_CTRL, 32'(UCPWM_MODE_CENTER_PWM) | 32'h0000_2100);
        faultCheck(UCPWM_MODE_BMODCNT_0, 2'h2, 1'b0, 1'b1);                 // prescaler mismatch
        regCheck(UCPWM_OFS_STATUS, 32'h0000_0004, 32'h0000_0004);       // dead fault bit
        faultCheck(UCPWM_MODE_BMODCNT_1, 2'h1, 1'b0, 1'b0);                 // prescalers equal
        regWrite(UCPWM_OFS_CTRL, 32'(UCPWM_MODE_CENTER_PWM) | 32'h0000_0100);
        faultCheck(UCPWM_MODE_BMODCNT_0, 2'h2, 1'b0, 1'b0);                 // no dead time
        endSim();
    end

endmodule : test_pwm_channel_counter_modes

`default_nettype wire
